/* File: seq_stack_pkg.sv */
// Purpose: Shared constants and types for the channel sequence stack.
// Assumes: APB with 32-bit data; each stack entry is one aligned word.
// Notes: Entry index is the six-bit register address; byte address is 4x.
package seq_stack_pkg;

  // Stack geometry
  localparam int unsigned NUM_ENTRIES = 4;
  localparam int unsigned ENTRY_IDX_W = 2;
  localparam int unsigned ENTRY_W = 16;
  localparam int unsigned ADDR_W = 8;

  // Printed register indices (six-bit address field values)
  localparam logic [5:0] IDX_ENTRY_ZERO = 6'h20;
  localparam logic [5:0] IDX_ENTRY_ONE = 6'h21;
  localparam logic [5:0] IDX_ENTRY_TWO = 6'h22;
  localparam logic [5:0] IDX_ENTRY_THREE = 6'h23;
  // Own control and status registers (indices)
  localparam logic [5:0] IDX_SEQ_CTRL = 6'h30;
  localparam logic [5:0] IDX_SEQ_STATUS = 6'h31;

  // Field positions inside an entry word
  localparam int unsigned ACCESS_BIT = 15;
  localparam int unsigned ADDR_MSB = 14;
  localparam int unsigned ADDR_LSB = 9;
  localparam int unsigned RETURN_BIT = 8;
  localparam int unsigned CHAN_B_MSB = 7;
  localparam int unsigned CHAN_B_LSB = 4;
  localparam int unsigned CHAN_A_MSB = 3;
  localparam int unsigned CHAN_A_LSB = 0;

  // Reset values of the entries
  localparam logic [15:0] RESET_ENTRY_ZERO = 16'h4000;
  localparam logic [15:0] RESET_ENTRY_ONE = 16'h4211;
  localparam logic [15:0] RESET_ENTRY_TWO = 16'h4422;
  localparam logic [15:0] RESET_ENTRY_THREE = 16'h4633;

  // Control register fields
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam logic [31:0] RESET_SEQ_CTRL = 32'h00000000;

  // Sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_CONVERT = 3'b010,
    SEQ_ADVANCE = 3'b100
  } seq_state_t;

endpackage

/* File: seq_entry_if.sv */
// Purpose: Carries the active entry's fields from stack to sequencer.
// Assumes: One clock domain.
// Notes: The stack drives fields, the sequencer drives the index.
`timescale 1ns/10ps
`default_nettype none
interface seq_entry_if;
  logic [1:0] active_index;
  logic return_to_first_entry;
  logic [3:0] converter_a_channel;
  logic [3:0] converter_b_channel;

  modport stack (
    input active_index,
    output return_to_first_entry,
    output converter_a_channel,
    output converter_b_channel
  );
  modport sequencer (
    output active_index,
    input return_to_first_entry,
    input converter_a_channel,
    input converter_b_channel
  );
endinterface
`default_nettype wire

/* File: seq_entry_store.sv */
// Purpose: Holds the four sequence entry words.
// Assumes: Writes arrive one word per cycle from the bus slave.
// Notes: Access bit and address field are fixed; only bits 8..0 store.
`timescale 1ns/10ps
`default_nettype none
module seq_entry_store (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [1:0] wr_index_in,
  input wire logic [8:0] wr_data_in,
  input wire logic [1:0] rd_index_in,
  output logic [15:0] rd_data_out,
  seq_entry_if.stack entry_port
);
  import seq_stack_pkg::*;

  logic [8:0] entry_reg [NUM_ENTRIES];
  logic [8:0] entry_next [NUM_ENTRIES];

  // Write port; reset leaves each entry at its documented value
  always_comb begin
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      entry_next[i] = entry_reg[i];
    end
    if (wr_en_in) begin
      entry_next[wr_index_in] = wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      entry_reg[0] <= RESET_ENTRY_ZERO[8:0];
      entry_reg[1] <= RESET_ENTRY_ONE[8:0];
      entry_reg[2] <= RESET_ENTRY_TWO[8:0];
      entry_reg[3] <= RESET_ENTRY_THREE[8:0];
    end else begin
      for (int i = 0; i < NUM_ENTRIES; i++) begin
        entry_reg[i] <= entry_next[i];
      end
    end
  end

  // Readback rebuilds the word: access bit reads 0, address is fixed
  // Address field is 1000b over the two index bits, then the stored nine
  always_comb begin
    rd_data_out = {1'b0, 4'h8, rd_index_in, entry_reg[rd_index_in]};
  end

  // Fields of the entry the sequencer is sitting on
  always_comb begin
    entry_port.return_to_first_entry =
      entry_reg[entry_port.active_index][RETURN_BIT];
    entry_port.converter_b_channel =
      entry_reg[entry_port.active_index][CHAN_B_MSB:CHAN_B_LSB];
    entry_port.converter_a_channel =
      entry_reg[entry_port.active_index][CHAN_A_MSB:CHAN_A_LSB];
  end
endmodule
`default_nettype wire

/* File: seq_stepper.sv */
// Purpose: Steps through the stack as conversions complete.
// Assumes: conv_done_in is a one-cycle pulse per finished conversion.
// Notes: Channel pair registers update only between conversions.
`timescale 1ns/10ps
`default_nettype none
module seq_stepper (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic conv_start_in,
  input wire logic conv_done_in,
  output logic busy_out,
  output logic [3:0] chan_a_out,
  output logic [3:0] chan_b_out,
  seq_entry_if.sequencer entry_port
);
  import seq_stack_pkg::*;

  seq_state_t state_reg, state_next;
  logic [1:0] index_reg, index_next;
  logic [3:0] chan_a_reg, chan_a_next;
  logic [3:0] chan_b_reg, chan_b_next;

  assign entry_port.active_index = index_reg;
  assign busy_out = state_reg == SEQ_CONVERT;
  assign chan_a_out = chan_a_reg;
  assign chan_b_out = chan_b_reg;

  // Next-state logic for the entry walk
  always_comb begin
    state_next = state_reg;
    index_next = index_reg;
    chan_a_next = chan_a_reg;
    chan_b_next = chan_b_reg;
    unique case (state_reg)
      SEQ_IDLE: begin
        index_next = '0;
        chan_a_next = entry_port.converter_a_channel;
        chan_b_next = entry_port.converter_b_channel;
        if (enable_in && conv_start_in) begin
          state_next = SEQ_CONVERT;
        end
      end
      SEQ_CONVERT: begin
        if (conv_done_in) begin
          state_next = SEQ_ADVANCE;
          if (entry_port.return_to_first_entry) begin
            index_next = '0;
          end else begin
            index_next = index_reg + 2'h1;
          end
        end
      end
      SEQ_ADVANCE: begin
        // Latch the new pair for the conversion that follows
        chan_a_next = entry_port.converter_a_channel;
        chan_b_next = entry_port.converter_b_channel;
        if (!enable_in) begin
          state_next = SEQ_IDLE;
        end else if (conv_start_in) begin
          state_next = SEQ_CONVERT;
        end
      end
      default: state_next = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= SEQ_IDLE;
      index_reg <= 2'h0;
      chan_a_reg <= 4'h0;
      chan_b_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      index_reg <= index_next;
      chan_a_reg <= chan_a_next;
      chan_b_reg <= chan_b_next;
    end
  end
endmodule
`default_nettype wire

/* File: channel_sequence_stack_regs.sv */
// Purpose: APB register bank for the channel sequence stack.
// Assumes: APB3 master; conversion start/done strobes from the converter.
// Notes: Zero wait states; unmapped addresses answer with pslverr.
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Top bit of a command word picks read (0) or write (1); the bank uses pwrite instead and reads bit 15 back as 0.
// - Address field 100010b reaches entry two, 100011b entry three.
// - Return bit clear moves to the next entry after conversion.
// - Return bit set goes back to the first entry after conversion.
// - Bits 7..4 pick converter B's channel while the entry is active.
// - Bits 3..0 pick converter A's channel while the entry is active.
// - Entry two resets to 0x4422.
// - Entry three resets to 0x4633.
// - Entry zero at 0x20 is the first entry.
module channel_sequence_stack_regs (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [seq_stack_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_start_in,
  input wire logic conv_done_in,
  output logic [3:0] chan_a_out,
  output logic [3:0] chan_b_out,
  output logic seq_busy_out
);
  import seq_stack_pkg::*;

  seq_entry_if entry_bus ();

  logic setup;
  logic access;
  logic [5:0] idx;
  logic aligned;
  logic is_entry;
  logic is_ctrl;
  logic is_status;
  logic mapped;
  logic wr_en;
  logic [15:0] entry_rd;
  logic stepper_busy;
  logic [3:0] stepper_a;
  logic [3:0] stepper_b;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [3:0] chan_a_reg;
  logic [3:0] chan_b_reg;
  logic busy_reg;

  // Decode in setup phase; answer one cycle later in the access phase
  always_comb begin
    setup = psel && !penable;
    access = psel && penable && pready_reg;
    idx = paddr[7:2];
    aligned = paddr[1:0] == 2'h0;
    is_entry = aligned && idx[5:2] == IDX_ENTRY_ZERO[5:2];
    is_ctrl = aligned && idx == IDX_SEQ_CTRL;
    is_status = aligned && idx == IDX_SEQ_STATUS;
    mapped = is_entry || is_ctrl || is_status;
  end

  // Bus transfer direction selects read or write of the entry
  // Writes land only at the edge where the master sees pready high
  assign wr_en = access && pwrite && is_entry;

  seq_entry_store u_store (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(wr_en),
    .wr_index_in(idx[1:0]),
    .wr_data_in(pwdata[8:0]),
    .rd_index_in(idx[1:0]),
    .rd_data_out(entry_rd),
    .entry_port(entry_bus.stack)
  );

  seq_stepper u_stepper (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .enable_in(ctrl_reg[CTRL_ENABLE_BIT]),
    .conv_start_in(conv_start_in),
    .conv_done_in(conv_done_in),
    .busy_out(stepper_busy),
    .chan_a_out(stepper_a),
    .chan_b_out(stepper_b),
    .entry_port(entry_bus.sequencer)
  );

  // Control write, read mux and answer flags
  always_comb begin
    ctrl_next = ctrl_reg;
    prdata_next = 32'h00000000;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    // Control write waits for the access edge, like the entry writes
    if (access && pwrite && is_ctrl) begin
      ctrl_next = {31'h00000000, pwdata[CTRL_ENABLE_BIT]};
    end
    if (setup) begin
      pready_next = 1'b1;
      pslverr_next = !mapped;
      if (!pwrite) begin
        if (is_entry) begin
          prdata_next = {16'h0000, entry_rd};
        end else if (is_ctrl) begin
          prdata_next = ctrl_reg;
        end else if (is_status) begin
          prdata_next = {22'h000000, entry_bus.active_index,
                         stepper_b, stepper_a};
          prdata_next[31] = stepper_busy;
        end
      end
    end
  end

  // Everything leaving the block comes straight from a flop
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= RESET_SEQ_CTRL;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      chan_a_reg <= 4'h0;
      chan_b_reg <= 4'h0;
      busy_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      chan_a_reg <= stepper_a;
      chan_b_reg <= stepper_b;
      busy_reg <= stepper_busy;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign chan_a_out = chan_a_reg;
  assign chan_b_out = chan_b_reg;
  assign seq_busy_out = busy_reg;
endmodule
`default_nettype wire

/* File: seq_stack_monitor.sv */
// Purpose: Port assertions for the sequence stack bank.
// Assumes: Wait-free APB slave; sequencer stays enabled.
// Notes: Pair timing allows 2 or 3 cycles after a done pulse.
`timescale 1ns/10ps
`default_nettype none
module seq_stack_monitor (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [seq_stack_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_start_in,
  input wire logic conv_done_in,
  input wire logic [3:0] chan_a_out,
  input wire logic [3:0] chan_b_out,
  input wire logic seq_busy_out
);
  import seq_stack_pkg::*;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Bus answers exactly once, in the access cycle
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("answer outside access phase");
  // Misaligned places are refused and return nothing
  a_err_misaligned: assert property (psel && !penable &&
    paddr[1:0] != 2'h0 |=> pslverr) else $error("misaligned accepted");
  a_err_no_data: assert property (pslverr |-> prdata == 32'h00000000)
    else $error("refused access carried data");
  // Entry words read back with read flag clear and their own address
  a_entry_two_id: assert property (pready && !pwrite &&
    paddr == 8'h88 |-> prdata[15:9] == 7'h22) else $error("entry two id");
  a_entry_three_id: assert property (pready && !pwrite &&
    paddr == 8'h8C |-> prdata[15:9] == 7'h23) else $error("entry three id");
  // Pair moves only after a finished conversion, never mid-conversion
  a_pair_hold: assert property ($changed({chan_a_out, chan_b_out}) |->
    $past(conv_done_in, 2) || $past(conv_done_in, 3))
    else $error("channel pair moved without a done");
  a_busy_cause: assert property ($rose(seq_busy_out) |->
    $past(conv_start_in, 2)) else $error("busy without start");
endmodule
bind channel_sequence_stack_regs seq_stack_monitor mon (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .conv_start_in(conv_start_in), .conv_done_in(conv_done_in),
  .chan_a_out(chan_a_out), .chan_b_out(chan_b_out),
  .seq_busy_out(seq_busy_out));
`default_nettype wire

/* File: seq_host_model.sv */
// Purpose: Host that configures the stack over APB.
// Assumes: Slave answer time unknown; waits for pready.
// Notes: Released address and data lines show inverted values.
`timescale 1ns/10ps
`default_nettype none
module seq_host_model (
  input wire logic clk_in,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out
);
  initial begin
    {psel_out, penable_out, pwrite_out} = 3'h0;
    paddr_out = 8'h00;
    pwdata_out = 32'h00000000;
  end
  // One transfer; held unchanged until pready is seen high
  task automatic xfer(input logic wr, input logic [7:0] addr,
      input logic [31:0] wdata, output logic [31:0] rdata, output logic err);
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= wr;
    paddr_out <= addr;
    pwdata_out <= wdata;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    rdata = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    // Stale values would hide a slave that samples too late
    paddr_out <= ~addr;
    pwdata_out <= ~wdata;
  endtask
endmodule
`default_nettype wire

/* File: channel_sequence_stack_regs_tb.sv */
// Purpose: Self-checking bench for the sequence stack bank.
// Assumes: Pair settles within 4 cycles of a done pulse.
// Notes: Table rows first, then sequencing and a mid-run reset.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin \
  compares++; \
  if ((got) !== (ex)) begin \
    n_errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); \
  end \
end
module channel_sequence_stack_regs_tb;
  import seq_stack_pkg::*;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] wd;
    logic [31:0] ex; logic er;} row_t;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic conv_start_in = 1'b0;
  logic conv_done_in = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, seq_busy_out, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] chan_a_out, chan_b_out;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  // Only bits 8..0 of a written word are kept
  row_t rows [12] = '{'{0, 8'h88, 0, 32'h4422, 0}, '{0, 8'h8C, 0, 32'h4633, 0},
    '{0, 8'h80, 0, 32'h4000, 0}, '{1, 8'h88, 32'hFFFFF1A5, 0, 0},
    '{0, 8'h88, 0, 32'h45A5, 0}, '{1, 8'h8C, 32'h76, 0, 0},
    '{0, 8'h8C, 0, 32'h4676, 0}, '{1, 8'h84, 32'h54, 0, 0},
    '{0, 8'h84, 0, 32'h4254, 0}, '{0, 8'h89, 0, 0, 1},
    '{1, 8'h90, 32'h1FF, 0, 1}, '{1, 8'hC0, 32'h1, 0, 0}};
  logic [7:0] pairs [8] = '{8'h54, 8'hA5, 8'h00, 8'h54, 8'hA5, 8'h76, 8'h00,
    8'h54};
  always #50 ref_clk_in = ~ref_clk_in;
  channel_sequence_stack_regs dut (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_start_in(conv_start_in),
    .conv_done_in(conv_done_in), .chan_a_out(chan_a_out),
    .chan_b_out(chan_b_out), .seq_busy_out(seq_busy_out));
  seq_host_model host (.clk_in(ref_clk_in), .prdata_in(prdata),
    .pready_in(pready), .pslverr_in(pslverr), .psel_out(psel),
    .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
    .pwdata_out(pwdata));
  task automatic finish_test;
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One conversion, then the pair of the entry it moved to
  task automatic conv(input logic [7:0] ex);
    @(posedge ref_clk_in) conv_start_in <= 1'b1;
    @(posedge ref_clk_in) conv_start_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    `CHK("busy", 1'b1, seq_busy_out)
    conv_done_in <= 1'b1;
    @(posedge ref_clk_in) conv_done_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    `CHK("pair", ex, {chan_b_out, chan_a_out})
  endtask
  // Hang guard, far above the roughly 150 cycles the run needs
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      finish_test;
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    foreach (rows[i]) begin
      host.xfer(rows[i].wr, rows[i].a, rows[i].wd, rd, err);
      `CHK("pslverr", rows[i].er, err)
      if (!rows[i].wr) `CHK("prdata", rows[i].ex, rd)
    end
    // Entry two returns first, later cleared so the stack wraps
    for (int i = 0; i < 8; i++) begin
      if (i == 3) host.xfer(1'b1, 8'h88, 32'h0A5, rd, err);
      conv(pairs[i]);
    end
    // Parked on entry one with a nonzero pair, so the reset shows
    host.xfer(1'b0, 8'hC4, 32'h0, rd, err);
    `CHK("status", 32'h00000154, rd)
    rst_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    `CHK("reset_pair", 8'h00, {chan_b_out, chan_a_out})
    rst_n_in <= 1'b1;
    host.xfer(1'b0, 8'h88, 32'h0, rd, err);
    `CHK("entry_two_reset", 32'h4422, rd)
    host.xfer(1'b0, 8'h8C, 32'h0, rd, err);
    `CHK("entry_three_reset", 32'h4633, rd)
    finish_test;
  end
endmodule
`default_nettype wire
